// ==== phase_cfg_pkg.sv ====
// Package: command codes, field layouts, reset values and timing for the
// phase-shedding, frequency-protection and current-sharing settings block.
// Assumes a byte-wide management bus command port in the enclosing device.
package phase_cfg_pkg;

    // Command codes
    localparam logic [7:0] CMD_PHASE2TO3 = 8'hf2;
    localparam logic [7:0] CMD_PHASE3TO4 = 8'hf3;
    localparam logic [7:0] CMD_PHASE4TO5 = 8'hf4;
    localparam logic [7:0] CMD_PHASE5TO6 = 8'hf5;
    localparam logic [7:0] CMD_FREQ_PROTECT = 8'hf6;
    localparam logic [7:0] CMD_SHARE_GAINS = 8'hf7;
    localparam logic [7:0] CMD_FEEDFORWARD = 8'hf9;

    // Field layouts
    localparam int THR_MANT_MSB = 9;
    localparam int THR_EXP_LSB = 11;
    localparam int THR_EXP_MSB = 15;
    localparam int FP_WIN_MSB = 3;
    localparam int KI_LSB = 7;
    localparam int KI_MSB = 13;
    localparam int KP_MSB = 6;
    localparam int FF_CONST_LSB = 24;
    localparam int FF_CONST_MSB = 42;
    localparam int DUTY_HI_LSB = 19;
    localparam int DUTY_HI_MSB = 23;
    localparam int PH_ORDER_BIT = 18;
    localparam int PRECLAMP_BIT = 17;
    localparam int INTEG_MEM_BIT = 16;
    localparam int SS_CLAMP_LSB = 10;
    localparam int SS_CLAMP_MSB = 15;
    localparam int SECURE_OFF_BIT = 9;
    localparam int PULSE_MEM_BIT = 8;
    localparam int FF_GAIN_MSB = 7;

    // Writable bit masks; every other position is reserved and reads zero
    localparam logic [15:0] THR_MASK = 16'hfbff;
    localparam logic [7:0] FP_MASK = 8'h0f;
    localparam logic [15:0] SHARE_MASK = 16'h3fff;
    localparam logic [47:0] FF_MASK = 48'h07ff_ffff_ffff;

    // Values after reset
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam logic [7:0] FP_RESET = 8'h00;
    localparam logic [15:0] SHARE_RESET = 16'h0000;
    localparam logic [47:0] FF_RESET = 48'h0000_0003_0301;

    // Window and clamp constants
    localparam logic [4:0] FP_WINDOW_FULL = 5'h10;
    localparam logic [6:0] SS_CLAMP_TOP = 7'h3f;
    localparam logic [7:0] SS_CLAMP_STEP_MV = 8'h02;

    // Decoded settings handed to the control loop
    typedef struct packed {
        logic [9:0] thr_2to3;
        logic [9:0] thr_3to4;
        logic [9:0] thr_4to5;
        logic [9:0] thr_5to6;
        logic [4:0] fp_window;
        logic fp_active;
        logic share_resonant_on;
        logic share_bridge_on;
        logic [6:0] integral_gain;
        logic [6:0] proportional_gain;
        logic [18:0] ff_constant;
        logic [4:0] duty_threshold_hi;
        logic ph_order_sequential;
        logic pulse_memory_on;
        logic [7:0] ff_gain;
        logic ss_clamp_override;
        logic [7:0] softstart_error_clamp;
    } cfg_s;

    typedef enum logic [1:0] {
        PH_HOLD = 2'b00,
        PH_ADD = 2'b01,
        PH_DROP = 2'b11
    } ph_step_e;

endpackage : phase_cfg_pkg

// ==== shed_compare.sv ====
`timescale 1ns/1ps
// Phase-count decision: compares current against the four thresholds.
// Assumes currents arrive already in the same LSB weight as the thresholds.
module shed_compare
    import phase_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Thresholds and currents
    input wire logic [39:0] thr_i,
    input wire logic [9:0] ripple_comp_offset_i,
    input wire logic [11:0] iout_now_i,
    input wire logic [11:0] iout_avg_i,
    input wire logic [2:0] phases_i,
    // Decision
    output logic [1:0] step_o
);
    ////////////////////////////////////////////////////////////////////////
    // Transition index: 2 phases use threshold 0, up to 5 phases threshold 3
    logic [1:0] idx_up;
    logic [1:0] idx_dn;
    logic [11:0] thr_up;
    logic [11:0] thr_dn;
    logic can_up;
    logic can_dn;

    always_comb
    begin
        idx_up = 2'(phases_i - 3'd2);
        idx_dn = 2'(phases_i - 3'd3);
        can_up = (phases_i >= 3'd2) && (phases_i <= 3'd5);
        can_dn = (phases_i >= 3'd3) && (phases_i <= 3'd6);
        thr_up = {2'b00, thr_i[idx_up*10 +: 10]} + {2'b00, ripple_comp_offset_i};
        thr_dn = {2'b00, thr_i[idx_dn*10 +: 10]} - {2'b00, ripple_comp_offset_i};
        if (thr_i[idx_dn*10 +: 10] < ripple_comp_offset_i)
            thr_dn = 12'h000;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            step_o <= PH_HOLD;
        else if (can_up && iout_now_i > thr_up)
            step_o <= PH_ADD;
        else if (can_dn && iout_avg_i < thr_dn)
            step_o <= PH_DROP;
        else
            step_o <= PH_HOLD;
    end
endmodule : shed_compare

// ==== pulse_memory.sv ====
`timescale 1ns/1ps
// Pulse queue: holds oscillator requests that land during a running pulse.
// Assumes one request at most per clock and a busy level from the stage while a pulse runs.
module pulse_memory #(
    parameter int DEPTH_W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic enable_i,
    input wire logic request_i,
    input wire logic busy_i,
    // Fire strobe and pending count
    output logic fire_o,
    output logic [DEPTH_W-1:0] pending_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [DEPTH_W-1:0] next_pending;
    logic take_stored;

    // Stored pulses go out one at a time once the running pulse ends
    assign take_stored = !busy_i && !request_i && (pending_o != '0);

    always_comb
    begin
        next_pending = pending_o;
        if (request_i && busy_i && enable_i && (pending_o != '1))
            next_pending = pending_o + 1'b1;
        else if (take_stored)
            next_pending = pending_o - 1'b1;
        if (!enable_i)
            next_pending = '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            pending_o <= '0;
        else
            pending_o <= next_pending;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            fire_o <= 1'b0;
        else
            fire_o <= (request_i && !busy_i) || (take_stored && enable_i);
    end
endmodule : pulse_memory

// ==== phase_shed_current_share_cfg.sv ====
`timescale 1ns/1ps
// Settings block for phase shedding, frequency protection, current sharing
// and feed-forward control, with its decoded effects on the control loop.
// Assumes the bus engine delivers whole command words with a one-cycle strobe.
//
// What this block does
// - Four thresholds hold a 10-bit unsigned current for phase steps two to six.
// - Instantaneous current adds phases; averaged current removes phases.
// - Each threshold is shifted by the ripple offset before comparing.
// - Threshold reads form Linear words; Linear writes only with exponent equal to current_exponent_setting_i.
// - Frequency averaging window is sixteen minus field, zero field means none.
// - Frequency protection only in resonant adaptive loop, unless disabled.
// - Share register: integral gain bits 13:7, proportional gain bits 6:0.
// - Resonant sharing on when integral gain nonzero; lengthen start delay.
// - Bridge sharing on when proportional gain nonzero; widen pulse spacing.
// - Bits 42:24 hold the resonant feed-forward constant.
// - Bits 23:19 hold upper duty threshold bits; zero turns correction off.
// - Soft-start clamp is 2mV times 63 minus field; zero disables it.
// - Bit 18 picks sequential phase order, else shuffled.
// - Bit 8 stores oscillator pulses arriving during a pulse, in adaptive on-loop mode only.
module phase_shed_current_share_cfg
    import phase_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Command port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] cmd_i,
    input wire logic [47:0] wdata_i,
    output logic [47:0] rdata_o,
    output logic ack_o,
    output logic unsupported_o,
    // System settings
    input wire logic [4:0] current_exponent_setting_i,
    input wire logic [9:0] ripple_comp_offset_i,
    input wire logic protection_disable_bit_i,
    input wire logic adaptive_on_loop_mode_i,
    input wire logic resonant_topology_i,
    input wire logic softstart_i,
    // Loop signals
    input wire logic [11:0] iout_now_i,
    input wire logic [11:0] iout_avg_i,
    input wire logic [2:0] phases_i,
    input wire logic [7:0] duty_i,
    input wire logic pulse_oscillator_i,
    input wire logic pulse_busy_i,
    // Loop outputs
    output phase_cfg_pkg::cfg_s cfg_o,
    output logic [1:0] phase_step_o,
    output logic duty_correction_o,
    output logic phase_pulse_o,
    output logic [3:0] pulse_pending_o
);
    import phase_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0] thr [4];
    logic [7:0] freq_protect_window;
    logic [15:0] current_share_gains;
    logic [47:0] feedforward_control;

    function automatic logic is_thr(input logic [7:0] c);
        is_thr = (c >= CMD_PHASE2TO3) && (c <= CMD_PHASE5TO6);
    endfunction : is_thr

    logic thr_ok;
    // Linear write only with matching exponent
    assign thr_ok = (wdata_i[THR_EXP_MSB:THR_EXP_LSB] == current_exponent_setting_i);

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_thr
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                    thr[g] <= THR_RESET;
                else if (wr_i && cmd_i == CMD_PHASE2TO3 + 8'(g) && thr_ok)
                    thr[g] <= wdata_i[15:0] & THR_MASK;
            end
        end
    endgenerate

    // masked writes keep reserved bits zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            freq_protect_window <= FP_RESET;
        else if (wr_i && cmd_i == CMD_FREQ_PROTECT)
            freq_protect_window <= wdata_i[7:0] & FP_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            current_share_gains <= SHARE_RESET;
        else if (wr_i && cmd_i == CMD_SHARE_GAINS)
            current_share_gains <= wdata_i[15:0] & SHARE_MASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            feedforward_control <= FF_RESET;
        else if (wr_i && cmd_i == CMD_FEEDFORWARD)
            feedforward_control <= wdata_i & FF_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back and acknowledge
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_o <= 48'h0;
            ack_o <= 1'b0;
            unsupported_o <= 1'b0;
        end
        else
        begin
            ack_o <= wr_i || rd_i;
            unsupported_o <= wr_i && is_thr(cmd_i) && !thr_ok;
            if (rd_i)
            begin
                unique case (cmd_i)
                    // exponent field reads as Linear word
                    CMD_PHASE2TO3, CMD_PHASE3TO4, CMD_PHASE4TO5, CMD_PHASE5TO6:
                        rdata_o <= {32'h0, thr[2'(cmd_i - CMD_PHASE2TO3)]};
                    CMD_FREQ_PROTECT:
                        rdata_o <= {40'h0, freq_protect_window};
                    CMD_SHARE_GAINS:
                        rdata_o <= {32'h0, current_share_gains};
                    CMD_FEEDFORWARD:
                        rdata_o <= feedforward_control;
                    default:
                        rdata_o <= 48'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings
    logic [5:0] ss_field;
    logic [4:0] duty_hi;
    assign ss_field = feedforward_control[SS_CLAMP_MSB:SS_CLAMP_LSB];
    assign duty_hi = feedforward_control[DUTY_HI_MSB:DUTY_HI_LSB];

    // One register group per concern; cfg_o below is only their wiring
    logic [9:0] thr_mant [4];
    logic [4:0] fp_window;
    logic fp_active;
    logic share_resonant_on;
    logic share_bridge_on;
    logic [6:0] integral_gain;
    logic [6:0] proportional_gain;
    logic [18:0] ff_constant;
    logic [4:0] duty_threshold_hi;
    logic ph_order_sequential;
    logic pulse_memory_on;
    logic [7:0] ff_gain;
    logic ss_clamp_override;
    logic [7:0] softstart_error_clamp;

    generate
        for (g = 0; g < 4; g++)
        begin : g_mant
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                    thr_mant[g] <= 10'h000;
                else
                    thr_mant[g] <= thr[g][THR_MANT_MSB:0];
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            fp_window <= 5'h00;
        else if (freq_protect_window[FP_WIN_MSB:0] == 4'h0)
            fp_window <= 5'h00;
        else
            fp_window <= FP_WINDOW_FULL - {1'b0, freq_protect_window[FP_WIN_MSB:0]};
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            fp_active <= 1'b0;
        else
            fp_active <= resonant_topology_i && adaptive_on_loop_mode_i
                && !protection_disable_bit_i;
    end

    // The topology picks which gain switches sharing on
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            integral_gain <= 7'h00;
            proportional_gain <= 7'h00;
            share_resonant_on <= 1'b0;
            share_bridge_on <= 1'b0;
        end
        else
        begin
            integral_gain <= current_share_gains[KI_MSB:KI_LSB];
            proportional_gain <= current_share_gains[KP_MSB:0];
            share_resonant_on <= resonant_topology_i
                && (current_share_gains[KI_MSB:KI_LSB] != 7'h00);
            share_bridge_on <= !resonant_topology_i
                && (current_share_gains[KP_MSB:0] != 7'h00);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ff_constant <= 19'h00000;
            duty_threshold_hi <= 5'h00;
            ph_order_sequential <= 1'b0;
            pulse_memory_on <= 1'b0;
            ff_gain <= 8'h00;
        end
        else
        begin
            // constant used for resonant loop only
            ff_constant <= resonant_topology_i
                ? feedforward_control[FF_CONST_MSB:FF_CONST_LSB] : 19'h00000;
            duty_threshold_hi <= duty_hi;
            ph_order_sequential <= feedforward_control[PH_ORDER_BIT];
            pulse_memory_on <= feedforward_control[PULSE_MEM_BIT];
            ff_gain <= feedforward_control[FF_GAIN_MSB:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ss_clamp_override <= 1'b0;
            softstart_error_clamp <= 8'h00;
        end
        else
        begin
            ss_clamp_override <= softstart_i && (ss_field != 6'h00);
            softstart_error_clamp <= 8'(SS_CLAMP_STEP_MV * (SS_CLAMP_TOP - {1'b0, ss_field}));
        end
    end

    assign cfg_o = '{
        thr_2to3: thr_mant[0],
        thr_3to4: thr_mant[1],
        thr_4to5: thr_mant[2],
        thr_5to6: thr_mant[3],
        fp_window: fp_window,
        fp_active: fp_active,
        share_resonant_on: share_resonant_on,
        share_bridge_on: share_bridge_on,
        integral_gain: integral_gain,
        proportional_gain: proportional_gain,
        ff_constant: ff_constant,
        duty_threshold_hi: duty_threshold_hi,
        ph_order_sequential: ph_order_sequential,
        pulse_memory_on: pulse_memory_on,
        ff_gain: ff_gain,
        ss_clamp_override: ss_clamp_override,
        softstart_error_clamp: softstart_error_clamp
    };

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            duty_correction_o <= 1'b0;
        else
            duty_correction_o <= (duty_hi != 5'h00) && (duty_i[7:3] > duty_hi);
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase decisions and pulse memory
    shed_compare u_shed (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .thr_i({thr[3][9:0], thr[2][9:0], thr[1][9:0], thr[0][9:0]}),
        .ripple_comp_offset_i(ripple_comp_offset_i),
        .iout_now_i(iout_now_i),
        .iout_avg_i(iout_avg_i),
        .phases_i(phases_i),
        .step_o(phase_step_o)
    );

    pulse_memory #(.DEPTH_W(4)) u_mem (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(feedforward_control[PULSE_MEM_BIT] && adaptive_on_loop_mode_i),
        .request_i(pulse_oscillator_i),
        .busy_i(pulse_busy_i),
        .fire_o(phase_pulse_o),
        .pending_o(pulse_pending_o)
    );
endmodule : phase_shed_current_share_cfg

// ==== phase_cfg_props.sv ====
`timescale 1ns/1ps
// Checker: port-level properties of the settings block.
// Assumes one clock domain with a synchronous active-high reset.
module phase_cfg_props
    import phase_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Command port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] cmd_i,
    input wire logic [47:0] wdata_i,
    input wire logic [47:0] rdata_o,
    input wire logic ack_o,
    input wire logic unsupported_o,
    input wire logic [4:0] current_exponent_setting_i,
    // Loop
    input wire logic softstart_i,
    input wire logic pulse_oscillator_i,
    input wire logic pulse_busy_i,
    input wire phase_cfg_pkg::cfg_s cfg_o,
    input wire logic [1:0] phase_step_o,
    input wire logic phase_pulse_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////
    sequence s_gain_wr;
        wr_i && cmd_i == CMD_SHARE_GAINS;
    endsequence
    sequence s_thr_wr;
        wr_i && cmd_i >= CMD_PHASE2TO3 && cmd_i <= CMD_PHASE5TO6;
    endsequence
    chk_ack_follows_req: assert property ((wr_i || rd_i) |=> ack_o)
        else $error("ack missing after request");
    chk_no_spur_ack: assert property (!(wr_i || rd_i) |=> !ack_o)
        else $error("ack without request");
    chk_thr_exp_refuse: assert property (s_thr_wr |=>
        unsupported_o == $past(wdata_i[15:11] != current_exponent_setting_i))
        else $error("exponent refusal wrong");
    // Decoded gains land two edges after the write
    chk_gain_decode: assert property (s_gain_wr ##1 !wr_i |=>
        cfg_o.integral_gain == $past(wdata_i[13:7], 2)
        && cfg_o.proportional_gain == $past(wdata_i[6:0], 2))
        else $error("gain fields misplaced");
    chk_resv_read_zero: assert property (rd_i |=> rdata_o[47:43] == 5'h00)
        else $error("reserved bits read nonzero");
    chk_step_code: assert property (phase_step_o != 2'b10)
        else $error("illegal phase step code");
    chk_clamp_soft_only: assert property (cfg_o.ss_clamp_override |->
        $past(softstart_i) && !cfg_o.softstart_error_clamp[0]
        && cfg_o.softstart_error_clamp <= 8'h7c)
        else $error("soft-start clamp wrong");
    chk_pulse_idle_fire: assert property (pulse_oscillator_i && !pulse_busy_i |=> phase_pulse_o)
        else $error("idle request not fired");
endmodule : phase_cfg_props

// ==== mgmt_host.sv ====
`timescale 1ns/1ps
// Host model: one whole command word per strobe on the command port.
// Assumes the block answers one cycle after the strobe edge.
module mgmt_host (
    // Clock
    input wire logic clk_i,
    // Command port
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] cmd_o,
    output logic [47:0] wdata_o
);
    initial
    begin
        {wr_o, rd_o, cmd_o, wdata_o} = '0;
    end
    // Released data is inverted so stale words never look valid
    task automatic xfer(input logic w, input logic [7:0] c, input logic [47:0] d);
        @(negedge clk_i);
        wr_o = w;
        rd_o = !w;
        cmd_o = c;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = ~d;
    endtask : xfer
endmodule : mgmt_host

// ==== phase_shed_current_share_cfg_bench.sv ====
`timescale 1ns/1ps
// Bench: drives the settings block through the host model.
// Assumes fixed one-cycle answers, so waits are counted, not polled.
module phase_shed_current_share_cfg_bench;
    import phase_cfg_pkg::*;
    logic clk_i, reset_i, wr_i, rd_i, ack_o, unsupported_o, softstart_i;
    logic [7:0] cmd_i, duty_i;
    logic [47:0] wdata_i, rdata_o;
    logic [4:0] current_exponent_setting_i;
    logic [9:0] ripple_comp_offset_i;
    logic protection_disable_bit_i, adaptive_on_loop_mode_i, resonant_topology_i;
    logic [11:0] iout_now_i, iout_avg_i;
    logic [2:0] phases_i;
    logic pulse_oscillator_i, pulse_busy_i, duty_correction_o, phase_pulse_o;
    logic [1:0] phase_step_o;
    logic [3:0] pulse_pending_o;
    cfg_s cfg_o;
    int error_cnt = 0;
    int samples_checked = 0;
    int fires;
    logic [7:0] wins [3] = '{8'h00, 8'h01, 8'h0f};
    logic [7:0] cmds [7] = '{CMD_PHASE2TO3, CMD_PHASE3TO4, CMD_PHASE4TO5,
        CMD_PHASE5TO6, CMD_FREQ_PROTECT, CMD_SHARE_GAINS, CMD_FEEDFORWARD};
    phase_shed_current_share_cfg i_phase_shed_current_share_cfg (.clk_i, .reset_i,
        .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .ack_o, .unsupported_o,
        .current_exponent_setting_i, .ripple_comp_offset_i, .protection_disable_bit_i,
        .adaptive_on_loop_mode_i, .resonant_topology_i, .softstart_i, .iout_now_i,
        .iout_avg_i, .phases_i, .duty_i, .pulse_oscillator_i, .pulse_busy_i, .cfg_o,
        .phase_step_o, .duty_correction_o, .phase_pulse_o, .pulse_pending_o);
    mgmt_host i_mgmt_host (.clk_i, .wr_o(wr_i), .rd_o(rd_i), .cmd_o(cmd_i), .wdata_o(wdata_i));
    ////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    task automatic wr(input logic [7:0] c, input logic [47:0] d, input logic eu);
        i_mgmt_host.xfer(1'b1, c, d);
        chk(ack_o, 1'b1);
        chk(unsupported_o, eu);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [47:0] e);
        i_mgmt_host.xfer(1'b0, c, 48'h0);
        chk(ack_o, 1'b1);
        chk(rdata_o, e);
    endtask : rd
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial
    begin
        #100000;
        error_cnt++;
        test_done();
    end
    initial
    begin
        {reset_i, current_exponent_setting_i, ripple_comp_offset_i} = {1'b1, 15'h0};
        {protection_disable_bit_i, adaptive_on_loop_mode_i, resonant_topology_i} = 3'h0;
        {softstart_i, pulse_oscillator_i, pulse_busy_i, duty_i} = 11'h0;
        {iout_now_i, iout_avg_i, phases_i} = {24'h0, 3'd1};
        step(5);
        reset_i = 1'b0;
        for (int i = 0; i < 7; i++)
            rd(cmds[i], (i == 6) ? 48'h3_0301 : 48'h0);
        for (int i = 0; i < 4; i++)
            wr(cmds[i], 48'h07e0 + i, 1'b0);
        for (int i = 0; i < 4; i++)
            rd(cmds[i], 48'h03e0 + i);
        chk(cfg_o.thr_5to6, 10'h3e3);
        chk(cfg_o.thr_4to5, 10'h3e2);
        wr(CMD_PHASE2TO3, 48'h0814, 1'b1);
        rd(CMD_PHASE2TO3, 48'h03e0);
        current_exponent_setting_i = 5'h01;
        wr(CMD_PHASE2TO3, 48'h0814, 1'b0);
        rd(CMD_PHASE2TO3, 48'h0814);
        current_exponent_setting_i = 5'h00;
        wr(CMD_PHASE2TO3, 48'h0014, 1'b0);
        $display("test thresholds done");
        foreach (wins[i])
        begin
            wr(CMD_FREQ_PROTECT, 48'hf0 | wins[i], 1'b0);
            rd(CMD_FREQ_PROTECT, wins[i]);
            chk(cfg_o.fp_window, (wins[i] == 0) ? 8'h00 : 8'h10 - wins[i]);
        end
        {resonant_topology_i, adaptive_on_loop_mode_i} = 2'b11;
        step(2);
        chk(cfg_o.fp_active, 1'b1);
        protection_disable_bit_i = 1'b1;
        step(2);
        chk(cfg_o.fp_active, 1'b0);
        $display("test window done");
        wr(CMD_SHARE_GAINS, 48'hc080, 1'b0);
        rd(CMD_SHARE_GAINS, 48'h0080);
        chk(cfg_o.share_resonant_on, 1'b1);
        resonant_topology_i = 1'b0;
        wr(CMD_SHARE_GAINS, 48'h0001, 1'b0);
        step(1);
        chk(cfg_o.share_bridge_on, 1'b1);
        chk(cfg_o.share_resonant_on, 1'b0);
        $display("test gains done");
        {softstart_i, resonant_topology_i} = 2'b11;
        wr(CMD_FEEDFORWARD, {48{1'b1}}, 1'b0);
        rd(CMD_FEEDFORWARD, 48'h07ff_ffff_ffff);
        chk(cfg_o.ff_constant, 19'h7ffff);
        chk(cfg_o.duty_threshold_hi, 5'h1f);
        chk(cfg_o.ph_order_sequential, 1'b1);
        chk(cfg_o.softstart_error_clamp, 8'h00);
        chk(cfg_o.pulse_memory_on, 1'b1);
        resonant_topology_i = 1'b0;
        step(2);
        chk(cfg_o.ff_constant, 19'h00000);
        wr(CMD_FEEDFORWARD, 48'h23_0701, 1'b0);
        duty_i = 8'h28;
        step(2);
        chk(cfg_o.softstart_error_clamp, 8'h7c);
        chk(cfg_o.ph_order_sequential, 1'b0);
        chk(cfg_o.ff_gain, 8'h01);
        chk(duty_correction_o, 1'b1);
        {duty_i, softstart_i} = {8'h20, 1'b0};
        step(2);
        chk(duty_correction_o, 1'b0);
        chk(cfg_o.ss_clamp_override, 1'b0);
        $display("test feed-forward done");
        ripple_comp_offset_i = 10'h002;
        {phases_i, iout_now_i, iout_avg_i} = {3'd2, 12'd23, 12'd30};
        step(2);
        chk(phase_step_o, PH_ADD);
        iout_now_i = 12'd22;
        step(2);
        chk(phase_step_o, PH_HOLD);
        {phases_i, iout_now_i, iout_avg_i} = {3'd3, 12'd0, 12'd17};
        step(2);
        chk(phase_step_o, PH_DROP);
        iout_avg_i = 12'd18;
        step(2);
        chk(phase_step_o, PH_HOLD);
        $display("test phase step done");
        adaptive_on_loop_mode_i = 1'b1;
        wr(CMD_FEEDFORWARD, 48'h03_0301, 1'b0);
        {pulse_busy_i, pulse_oscillator_i} = 2'b11;
        step(2);
        pulse_oscillator_i = 1'b0;
        step(1);
        chk(pulse_pending_o, 4'h2);
        {pulse_busy_i, fires} = {1'b0, 32'd0};
        repeat (6)
        begin
            step(1);
            fires += phase_pulse_o;
        end
        chk(fires, 2);
        wr(CMD_FEEDFORWARD, 48'h03_0201, 1'b0);
        {pulse_busy_i, pulse_oscillator_i} = 2'b11;
        step(1);
        chk(phase_pulse_o, 1'b0);
        {pulse_busy_i, pulse_oscillator_i} = 2'b01;
        step(1);
        chk(phase_pulse_o, 1'b1);
        chk(pulse_pending_o, 4'h0);
        pulse_oscillator_i = 1'b0;
        step(1);
        chk(phase_pulse_o, 1'b0);
        $display("test pulse memory done");
        test_done();
    end
endmodule : phase_shed_current_share_cfg_bench
bind phase_shed_current_share_cfg phase_cfg_props i_phase_cfg_props (.clk_i, .reset_i,
    .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .ack_o, .unsupported_o,
    .current_exponent_setting_i, .softstart_i, .pulse_oscillator_i, .pulse_busy_i,
    .cfg_o, .phase_step_o, .phase_pulse_o);
